/* inc/rx_status_pkg.sv */
// Overview of operation
// [R1] e1 mode: hdlc source select 0 feeds time slots, 1 feeds the Sa bits
// [R2] receive hdlc runs only while its enable bit is 1
// [R3] bert direction 0 takes framer data, 1 takes the transmit path
// [R4] t1 only: framed select 0 skips the F-bit, 1 clocks it too
// [R5] receive bert port runs only while its enable bit is 1
// [R6] bert suppress mask bit k set excludes channel bit k+1
// [R7] hdlc suppress mask excludes channel bits; in Sa mode bits 4..0 exclude Sa4..Sa8
// [R8] clear bits set on falling edge, detect bits on rising edge of alarm
// [R9] flag all-ones alarm and remote alarm arriving on the receive line
// [R10] loss of signal declared after 192 consecutive received zeros
// [R11] frame loss detect sets when receiver loses synchronization
// [R12] first and t1 third status registers latched and can request interrupt
// [R13] port n copy sits at base plus 200h times n minus one
// [R14] t1: alignment change event sets when last resync moved alignment
// [R15] t1: separate events for zero runs of at least eight and sixteen
// [R16] t1: severe framing event when 2 of 6 framing bits errored
// [R17] t1: zero-substitution codeword event regardless of selected line code
// [R18] t1: frame bit error event on each errored Ft or FPS bit
// [R19] e1: crc, cas and fas resync criteria events
// [R20] e1: signaling all-ones and all-zeros events on time slot 16
// [R21] e1: crc-4 multiframe event and align frame event
// [R22] second register latched; t1 no interrupt, e1 only bits 0 to 3
// [R23] latched bits stay set until the host clears them
package rx_status_pkg;
  localparam int          PORT_COUNT   = 8;
  localparam int          ADDR_W       = 14;
  // register indices inside one port window; byte address is four times the index
  localparam logic [8:0]  IDX_CTL      = 9'h08A;
  localparam logic [8:0]  IDX_BERT_SUP = 9'h08B;
  localparam logic [8:0]  IDX_HDLC_SUP = 9'h08D;
  localparam logic [8:0]  IDX_CFG      = 9'h08E;
  localparam logic [8:0]  IDX_ALARM_ST = 9'h090;
  localparam logic [8:0]  IDX_FRAME_ST = 9'h091;
  localparam logic [8:0]  IDX_LOOP_ST  = 9'h092;
  localparam logic [11:0] PORT_STRIDE  = 12'h200;
  // expansion port control fields
  localparam int          CTL_HDLC_SRC = 7;
  localparam int          CTL_HDLC_EN  = 6;
  localparam int          CTL_BERT_DIR = 2;
  localparam int          CTL_BERT_FRM = 1;
  localparam int          CTL_BERT_EN  = 0;
  localparam logic [7:0]  CTL_MASK     = 8'hC7;
  localparam int          CFG_E1       = 0;
  localparam logic [7:0]  CFG_MASK     = 8'h01;
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  // status layout
  localparam int          ALRM_CLR_OFS = 4;
  localparam logic [7:0]  FRAME_T1_MSK = 8'h3F;
  localparam logic [7:0]  FRAME_T1_LOW = 8'h07;
  localparam logic [7:0]  FRAME_E1_MSK = 8'h7F;
  localparam logic [7:0]  FRAME_E1_IRQ = 8'h0F;
  localparam int          FRAME_Z8     = 4;
  localparam int          FRAME_Z16    = 3;
  localparam int          FRAME_ALIGN  = 5;
  localparam int          LOOP_CLK_CLR = 7;
  localparam int          LOOP_CLK_DET = 3;
  // raw input bundle positions
  localparam int          RAW_W        = 13;
  localparam int          RAW_CLK_LOSS = 3;
  localparam int          RAW_EV       = 4;
  localparam int          RAW_TOG      = 11;
  localparam int          RAW_DATA     = 12;
  localparam int          EV_W         = 7;
  // zero run figures
  localparam logic [7:0]  LOS_ZEROS    = 8'd192;
  localparam logic [7:0]  RUN_EIGHT    = 8'd8;
  localparam logic [7:0]  RUN_SIXTEEN  = 8'd16;
endpackage

/* rtl/rx_port_status.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_port_status (
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst_n,
  input  wire logic                                 e1Mode,
  input  wire logic [rx_status_pkg::RAW_W-1:0]      rawIn,
  input  wire logic [7:0]                           clear1,
  input  wire logic [7:0]                           clear2,
  input  wire logic [7:0]                           clear3,
  output logic      [7:0]                           alarmSt,
  output logic      [7:0]                           frameSt,
  output logic      [7:0]                           loopSt,
  output logic                                      irqRequest
);
  typedef struct packed {
    logic [rx_status_pkg::RAW_W-1:0] s1;
    logic [rx_status_pkg::RAW_W-1:0] s2;
    logic [rx_status_pkg::RAW_W-1:0] s3;
    logic [rx_status_pkg::RAW_W-1:0] agreed;
    logic [3:0]                      condPrev;
    logic [7:0]                      zeroCount;
    logic [7:0]                      alarmSt;
    logic [7:0]                      frameSt;
    logic [7:0]                      loopSt;
  } pstate_t;

  pstate_t                         state;
  pstate_t                         next_state;
  logic [rx_status_pkg::RAW_W-1:0] agreedNew;
  logic [rx_status_pkg::RAW_W-1:0] change;
  logic [3:0]                      cond;
  logic [3:0]                      condRise;
  logic [3:0]                      condFall;
  logic                            bitTick;
  logic                            losLevel;
  logic [7:0]                      set2;

  // change counts only once the second and third stage agree
  always_comb begin
    next_state = state;
    next_state.s1 = rawIn;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    for (int i = 0; i < rx_status_pkg::RAW_W; i++) begin
      agreedNew[i] = (state.s2[i] == state.s3[i]) ? state.s3[i] : state.agreed[i];
    end
    next_state.agreed = agreedNew;
    change = agreedNew ^ state.agreed;
    // each toggle of the bit strobe carries one received line bit
    bitTick = change[rx_status_pkg::RAW_TOG];
    if (bitTick) begin
      if (agreedNew[rx_status_pkg::RAW_DATA]) begin
        next_state.zeroCount = '0;
      end else if (state.zeroCount != rx_status_pkg::LOS_ZEROS) begin
        next_state.zeroCount = state.zeroCount + 8'h01;
      end
    end
    losLevel = (next_state.zeroCount == rx_status_pkg::LOS_ZEROS); // R10
    // remote alarm, all-ones, signal loss, frame loss
    cond = {agreedNew[2], agreedNew[1], losLevel, agreedNew[0]}; // R9 R11
    next_state.condPrev = cond;
    condRise = cond & ~state.condPrev;
    condFall = ~cond & state.condPrev;
    // set wins over a clear in the same cycle
    next_state.alarmSt = (state.alarmSt & ~clear1) | {condFall, condRise}; // R8 R12 R23
    // event inputs are toggles; every agreed change is one event
    set2 = {1'b0, change[rx_status_pkg::RAW_EV +: rx_status_pkg::EV_W]}; // R19 R20 R21
    if (!e1Mode) begin
      set2 = set2 & rx_status_pkg::FRAME_T1_LOW; // R16 R17 R18
      set2[rx_status_pkg::FRAME_ALIGN] =
        change[rx_status_pkg::RAW_EV + rx_status_pkg::FRAME_ALIGN]; // R14
      set2[rx_status_pkg::FRAME_Z8] = bitTick
        && (next_state.zeroCount == rx_status_pkg::RUN_EIGHT); // R15
      set2[rx_status_pkg::FRAME_Z16] = bitTick
        && (next_state.zeroCount == rx_status_pkg::RUN_SIXTEEN); // R15
      set2 = set2 & rx_status_pkg::FRAME_T1_MSK;
    end else begin
      set2 = set2 & rx_status_pkg::FRAME_E1_MSK;
    end
    next_state.frameSt = (state.frameSt & ~clear2) | set2; // R22 R23
    next_state.loopSt = state.loopSt & ~clear3;
    next_state.loopSt[rx_status_pkg::LOOP_CLK_DET] =
      next_state.loopSt[rx_status_pkg::LOOP_CLK_DET]
      | (change[rx_status_pkg::RAW_CLK_LOSS] & agreedNew[rx_status_pkg::RAW_CLK_LOSS]);
    next_state.loopSt[rx_status_pkg::LOOP_CLK_CLR] =
      next_state.loopSt[rx_status_pkg::LOOP_CLK_CLR]
      | (change[rx_status_pkg::RAW_CLK_LOSS] & ~agreedNew[rx_status_pkg::RAW_CLK_LOSS]); // R12
  end

  // single register for all port state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign alarmSt = state.alarmSt;
  assign frameSt = state.frameSt;
  assign loopSt  = state.loopSt;
  // t1 second register never requests; e1 only its low four bits
  assign irqRequest = (|state.alarmSt) || (|state.loopSt)
                      || (e1Mode && |(state.frameSt & rx_status_pkg::FRAME_E1_IRQ)); // R12 R22

  los_192_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    $rose(state.alarmSt[1]) |-> $past(state.zeroCount) == rx_status_pkg::LOS_ZEROS - 8'h01
    || $past(state.zeroCount) == rx_status_pkg::LOS_ZEROS)
    else $error("signal loss set without 192 zeros");
  sticky_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R23
    (state.alarmSt[4] && !clear1[4]) |=> state.alarmSt[4])
    else $error("latched bit dropped without clear");
  set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    (condRise[0] && clear1[0]) |=> state.alarmSt[0])
    else $error("rising edge lost under clear");
  fall_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    condFall[2] |=> state.alarmSt[6] && !$past(cond[2]))
    else $error("falling edge did not set clear bit");
  t1_no_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R22
    (!e1Mode && state.alarmSt == 8'h00 && state.loopSt == 8'h00) |-> !irqRequest)
    else $error("t1 second register raised a request");
  // an older sixteen-zero bit may still be latched, so only a new rise is wrong
  zero_eight_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
    (!e1Mode && bitTick && state.zeroCount == rx_status_pkg::RUN_EIGHT - 8'h01
     && !agreedNew[rx_status_pkg::RAW_DATA])
    |=> state.frameSt[rx_status_pkg::FRAME_Z8] && !$rose(state.frameSt[rx_status_pkg::FRAME_Z16]))
    else $error("eight zero event missing");
endmodule
`default_nettype wire

/* rtl/rx_port_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_port_ctl #(
  parameter int PORTS = rx_status_pkg::PORT_COUNT
) (
  input  wire logic                                   clk_sys,
  input  wire logic                                   rst_n,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [rx_status_pkg::ADDR_W-1:0]       paddr,
  input  wire logic [31:0]                            pwdata,
  input  wire logic [3:0]                             pstrb,
  output logic      [31:0]                            prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic [PORTS-1:0]                       remoteAlarmRaw,
  input  wire logic [PORTS-1:0]                       allOnesAlarmRaw,
  input  wire logic [PORTS-1:0]                       frameLossRaw,
  input  wire logic [PORTS-1:0]                       rxClockLossRaw,
  input  wire logic [PORTS-1:0][6:0]                  eventToggleRaw,
  input  wire logic [PORTS-1:0]                       lineBitToggle,
  input  wire logic [PORTS-1:0]                       lineBitData,
  output logic      [PORTS-1:0]                       e1Mode,
  output logic      [PORTS-1:0]                       hdlcSourceSa,
  output logic      [PORTS-1:0]                       hdlcSourceFdl,
  output logic      [PORTS-1:0]                       hdlcRun,
  output logic      [PORTS-1:0][7:0]                  hdlcChanSuppress,
  output logic      [PORTS-1:0][4:0]                  hdlcSaSuppress,
  output logic      [PORTS-1:0]                       bertFromTx,
  output logic      [PORTS-1:0]                       bertUseFbit,
  output logic      [PORTS-1:0]                       bertRun,
  output logic      [PORTS-1:0][7:0]                  bertSuppress,
  output logic      [PORTS-1:0]                       statusRequest
);
  typedef struct packed {
    logic [PORTS-1:0][7:0] ctl;
    logic [PORTS-1:0][7:0] bertSup;
    logic [PORTS-1:0][7:0] hdlcSup;
    logic [PORTS-1:0][7:0] cfg;
    logic [31:0]           rdata;
  } cstate_t;

  cstate_t               state;
  cstate_t               next_state;
  logic [2:0]            port;
  logic [8:0]            localIdx;
  logic                  hit;
  logic                  access;
  logic                  wrEn;
  logic [7:0]            wrByte;
  logic [PORTS-1:0][7:0] clear1;
  logic [PORTS-1:0][7:0] clear2;
  logic [PORTS-1:0][7:0] clear3;
  logic [PORTS-1:0][7:0] alarmSt;
  logic [PORTS-1:0][7:0] frameSt;
  logic [PORTS-1:0][7:0] loopSt;

  // index within a port window; ports repeat every stride of indices
  function automatic logic [8:0] local_index(input logic [rx_status_pkg::ADDR_W-1:0] a);
    return a[10:2];
  endfunction

  function automatic logic index_mapped(input logic [8:0] i);
    return i == rx_status_pkg::IDX_CTL || i == rx_status_pkg::IDX_BERT_SUP
        || i == rx_status_pkg::IDX_HDLC_SUP || i == rx_status_pkg::IDX_CFG
        || i == rx_status_pkg::IDX_ALARM_ST || i == rx_status_pkg::IDX_FRAME_ST
        || i == rx_status_pkg::IDX_LOOP_ST;
  endfunction

  // mask bit 4 goes to Sa4 and bit 0 to Sa8, so the order turns round
  function automatic logic [4:0] sa_order(input logic [7:0] m);
    return {m[0], m[1], m[2], m[3], m[4]};
  endfunction

  // address decode; upper address bits pick the port copy
  always_comb begin
    port   = paddr[rx_status_pkg::ADDR_W-1:11]; // R13
    localIdx = local_index(paddr);
    hit    = index_mapped(localIdx);
    access = psel && penable;
    wrEn   = access && pwrite && hit && pstrb[0];
    wrByte = pwdata[7:0];
  end

  // no wait states; unmapped indices answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = state.rdata;

  // writes to latched status clear the bits written as one
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      clear1[p] = '0;
      clear2[p] = '0;
      clear3[p] = '0;
    end
    if (wrEn) begin
      if (localIdx == rx_status_pkg::IDX_ALARM_ST) begin
        clear1[port] = wrByte; // R23
      end
      if (localIdx == rx_status_pkg::IDX_FRAME_ST) begin
        clear2[port] = wrByte;
      end
      if (localIdx == rx_status_pkg::IDX_LOOP_ST) begin
        clear3[port] = wrByte;
      end
    end
  end

  // register writes land at the access edge; read data captured in setup
  always_comb begin
    next_state = state;
    if (wrEn) begin
      unique case (localIdx)
        rx_status_pkg::IDX_CTL: begin
          next_state.ctl[port] = wrByte & rx_status_pkg::CTL_MASK;
        end
        rx_status_pkg::IDX_BERT_SUP: begin
          next_state.bertSup[port] = wrByte;
        end
        rx_status_pkg::IDX_HDLC_SUP: begin
          next_state.hdlcSup[port] = wrByte;
        end
        rx_status_pkg::IDX_CFG: begin
          next_state.cfg[port] = wrByte & rx_status_pkg::CFG_MASK;
        end
        default: begin
          next_state.cfg = state.cfg;
        end
      endcase
    end
    if (psel && !penable) begin
      next_state.rdata = '0;
      unique case (localIdx)
        rx_status_pkg::IDX_CTL:      next_state.rdata[7:0] = state.ctl[port];
        rx_status_pkg::IDX_BERT_SUP: next_state.rdata[7:0] = state.bertSup[port];
        rx_status_pkg::IDX_HDLC_SUP: next_state.rdata[7:0] = state.hdlcSup[port];
        rx_status_pkg::IDX_CFG:      next_state.rdata[7:0] = state.cfg[port];
        rx_status_pkg::IDX_ALARM_ST: next_state.rdata[7:0] = alarmSt[port];
        rx_status_pkg::IDX_FRAME_ST: next_state.rdata[7:0] = frameSt[port];
        rx_status_pkg::IDX_LOOP_ST:  next_state.rdata[7:0] = loopSt[port];
        default:                     next_state.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // per-port routing and status copies
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic saMode;

    assign e1Mode[p]        = state.cfg[p][rx_status_pkg::CFG_E1];
    assign saMode           = e1Mode[p] && state.ctl[p][rx_status_pkg::CTL_HDLC_SRC];
    assign hdlcSourceSa[p]  = saMode; // R1
    assign hdlcSourceFdl[p] = !e1Mode[p] && state.ctl[p][rx_status_pkg::CTL_HDLC_SRC];
    assign hdlcRun[p]       = state.ctl[p][rx_status_pkg::CTL_HDLC_EN]; // R2
    // channel mask is idle while the controller feeds from Sa bits
    assign hdlcChanSuppress[p] = saMode ? 8'h00 : state.hdlcSup[p]; // R7
    assign hdlcSaSuppress[p]   = saMode ? sa_order(state.hdlcSup[p]) : 5'h00; // R7
    assign bertFromTx[p]    = state.ctl[p][rx_status_pkg::CTL_BERT_DIR]; // R3
    // the F-bit exists only in t1 frames
    assign bertUseFbit[p]   = !e1Mode[p] && state.ctl[p][rx_status_pkg::CTL_BERT_FRM]; // R4
    assign bertRun[p]       = state.ctl[p][rx_status_pkg::CTL_BERT_EN]; // R5
    assign bertSuppress[p]  = state.bertSup[p]; // R6

    rx_port_status u_status (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .e1Mode     (e1Mode[p]),
      .rawIn      ({lineBitData[p], lineBitToggle[p], eventToggleRaw[p], rxClockLossRaw[p],
                    remoteAlarmRaw[p], allOnesAlarmRaw[p], frameLossRaw[p]}),
      .clear1     (clear1[p]),
      .clear2     (clear2[p]),
      .clear3     (clear3[p]),
      .alarmSt    (alarmSt[p]),
      .frameSt    (frameSt[p]),
      .loopSt     (loopSt[p]),
      .irqRequest (statusRequest[p])
    );
  end

  ctl_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    (wrEn && localIdx == rx_status_pkg::IDX_CTL)
    |=> state.ctl[$past(port)] == ($past(wrByte) & rx_status_pkg::CTL_MASK))
    else $error("control write not stored in addressed port");
  unmapped_err_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (access && !index_mapped(local_index(paddr))) |-> pslverr ##1 !$past(wrEn))
    else $error("unmapped access not refused");
  bert_fbit_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    bertUseFbit[2] |-> !e1Mode[2] && state.ctl[2][rx_status_pkg::CTL_BERT_FRM])
    else $error("F-bit used outside t1 framed select");
  sa_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    hdlcSaSuppress[3][0] |-> hdlcSourceSa[3] && state.hdlcSup[3][4] && hdlcChanSuppress[3] == 8'h00)
    else $error("Sa4 suppress mapped wrongly");
  hdlc_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    (hdlcSourceSa[2] |-> e1Mode[2]) and (hdlcSourceFdl[2] |-> !e1Mode[2]))
    else $error("hdlc source select wrong for mode");
endmodule
`default_nettype wire

/* bench/rx_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_line_model (
  input  wire logic       clk_sys,
  output logic [7:0]      remoteAlarmRaw,
  output logic [7:0]      allOnesAlarmRaw,
  output logic [7:0]      frameLossRaw,
  output logic [7:0]      rxClockLossRaw,
  output logic [7:0][6:0] eventToggleRaw,
  output logic [7:0]      lineBitToggle,
  output logic [7:0]      lineBitData
);
  // detectors quiet and line idle at time zero
  initial begin
    remoteAlarmRaw = 8'h00;
    allOnesAlarmRaw = 8'h00;
    frameLossRaw = 8'h00;
    rxClockLossRaw = 8'h00;
    eventToggleRaw = '0;
    lineBitToggle = 8'h00;
    lineBitData = 8'hFF;
  end
  // alarm level per kind: 0 remote, 1 all ones, 2 frame loss, 3 clock loss
  task automatic setAlarm(input int kind, input int port, input logic val);
    @(posedge clk_sys);
    case (kind)
      0: remoteAlarmRaw[port] <= val;
      1: allOnesAlarmRaw[port] <= val;
      2: frameLossRaw[port] <= val;
      default: rxClockLossRaw[port] <= val;
    endcase
  endtask
  // one framer event is one change of its toggle
  task automatic pulseEvent(input int port, input int bitNo);
    @(posedge clk_sys);
    eventToggleRaw[port][bitNo] <= ~eventToggleRaw[port][bitNo];
  endtask
  // data leads the toggle by a cycle so the sampler never takes a stale bit
  task automatic sendBits(input int port, input int count, input logic val);
    repeat (count) begin
      @(posedge clk_sys);
      lineBitData[port] <= val;
      @(posedge clk_sys);
      lineBitToggle[port] <= ~lineBitToggle[port];
    end
  endtask
endmodule
`default_nettype wire

/* bench/rx_port_ctl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_port_ctl_bench;
  // register order: ctl, bert sup, hdlc sup, cfg, status 1, 2, 3
  localparam logic [8:0] REGS [7] = '{rx_status_pkg::IDX_CTL, rx_status_pkg::IDX_BERT_SUP,
    rx_status_pkg::IDX_HDLC_SUP, rx_status_pkg::IDX_CFG, rx_status_pkg::IDX_ALARM_ST,
    rx_status_pkg::IDX_FRAME_ST, rx_status_pkg::IDX_LOOP_ST};
  localparam logic [7:0] DET [4] = '{8'h08, 8'h04, 8'h01, 8'h08};
  logic            clk_sys = 1'b0;
  logic            rst_n = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [13:0]     paddr = 14'h0000;
  logic [31:0]     pwdata = 32'h0000_0000;
  logic [3:0]      pstrb = 4'hF;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [7:0]      remoteAlarmRaw, allOnesAlarmRaw, frameLossRaw, rxClockLossRaw;
  logic [7:0]      lineBitToggle, lineBitData, e1Mode, hdlcSourceSa, hdlcSourceFdl;
  logic [7:0]      hdlcRun, bertFromTx, bertUseFbit, bertRun, statusRequest;
  logic [7:0][6:0] eventToggleRaw;
  logic [7:0][7:0] hdlcChanSuppress, bertSuppress;
  logic [7:0][4:0] hdlcSaSuppress;
  logic [31:0]     rd;
  logic            rdErr;
  int              err_total = 0;
  int              checks = 0;
  int              cycles = 0;

  always #20 clk_sys = ~clk_sys;

  rx_port_ctl #(.PORTS(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .remoteAlarmRaw(remoteAlarmRaw),
    .allOnesAlarmRaw(allOnesAlarmRaw), .frameLossRaw(frameLossRaw),
    .rxClockLossRaw(rxClockLossRaw), .eventToggleRaw(eventToggleRaw),
    .lineBitToggle(lineBitToggle), .lineBitData(lineBitData), .e1Mode(e1Mode),
    .hdlcSourceSa(hdlcSourceSa), .hdlcSourceFdl(hdlcSourceFdl), .hdlcRun(hdlcRun),
    .hdlcChanSuppress(hdlcChanSuppress), .hdlcSaSuppress(hdlcSaSuppress),
    .bertFromTx(bertFromTx), .bertUseFbit(bertUseFbit), .bertRun(bertRun),
    .bertSuppress(bertSuppress), .statusRequest(statusRequest));
  rx_line_model line (.clk_sys(clk_sys), .remoteAlarmRaw(remoteAlarmRaw),
    .allOnesAlarmRaw(allOnesAlarmRaw), .frameLossRaw(frameLossRaw),
    .rxClockLossRaw(rxClockLossRaw), .eventToggleRaw(eventToggleRaw),
    .lineBitToggle(lineBitToggle), .lineBitData(lineBitData));

  task automatic final_report;
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  // apb transfer held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input int port, input logic [8:0] idx, input logic [7:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {port[2:0], idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdChk(input int port, input logic [8:0] idx, input logic [7:0] want);
    apb(1'b0, port, idx, 8'h00);
    cmp(rd, {24'h000000, want});
  endtask
  // synchroniser plus latch take four edges; margin for the host read
  task automatic settle;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic resetValues;
    for (int p = 0; p < 8; p += 7) begin
      for (int i = 0; i < 7; i++) rdChk(p, REGS[i], 8'h00);
    end
  endtask
  task automatic ctlRouting;
    apb(1'b1, 2, REGS[3], 8'h01);
    apb(1'b1, 2, REGS[0], 8'hFF);
    rdChk(2, REGS[0], 8'hC7);
    @(negedge clk_sys);
    cmp(hdlcSourceSa[2], 1'b1);
    cmp(e1Mode[2], 1'b1);
    cmp(bertUseFbit[2], 1'b0);
    cmp(hdlcRun[2], 1'b1);
    cmp(bertFromTx[2], 1'b1);
    cmp(bertRun[2], 1'b1);
    cmp(hdlcRun[1], 1'b0);
    apb(1'b1, 2, REGS[3], 8'h00);
    @(negedge clk_sys);
    cmp(hdlcSourceSa[2], 1'b0);
    cmp(bertUseFbit[2], 1'b1);
    cmp(hdlcSourceFdl[2], 1'b1);
    apb(1'b1, 2, REGS[0], 8'h00);
    @(negedge clk_sys);
    cmp({hdlcRun[2], bertFromTx[2], bertUseFbit[2], bertRun[2]}, 4'h0);
  endtask
  task automatic suppress;
    apb(1'b1, 3, REGS[1], 8'h81);
    apb(1'b1, 3, REGS[2], 8'h18);
    pstrb <= 4'h0;
    apb(1'b1, 3, REGS[1], 8'h00);
    pstrb <= 4'hF;
    rdChk(3, REGS[1], 8'h81);
    @(negedge clk_sys);
    cmp(bertSuppress[3], 8'h81);
    cmp(hdlcChanSuppress[3], 8'h18);
    cmp(hdlcSaSuppress[3], 5'h00);
    // e1 with Sa source: mask bits 4 and 3 turn into Sa4 and Sa5
    apb(1'b1, 3, REGS[3], 8'h01);
    apb(1'b1, 3, REGS[0], 8'h80);
    @(negedge clk_sys);
    cmp(hdlcSaSuppress[3], 5'h03);
    cmp(hdlcChanSuppress[3], 8'h00);
    apb(1'b1, 3, 9'h08C, 8'h55);
    cmp(rdErr, 1'b1);
    rdChk(3, 9'h08C, 8'h00);
    cmp(rdErr, 1'b1);
  endtask
  // rise, fall, then write-one-to-clear each half
  task automatic alarms;
    logic [8:0] idx;
    for (int k = 0; k < 4; k++) begin
      idx = (k == 3) ? REGS[6] : REGS[4];
      line.setAlarm(k, 4, 1'b1);
      settle;
      rdChk(4, idx, DET[k]);
      cmp(statusRequest[4], 1'b1);
      line.setAlarm(k, 4, 1'b0);
      settle;
      rdChk(4, idx, DET[k] | (DET[k] << 4));
      apb(1'b1, 4, idx, DET[k]);
      rdChk(4, idx, DET[k] << 4);
      apb(1'b1, 4, idx, DET[k] << 4);
      rdChk(4, idx, 8'h00);
      @(negedge clk_sys);
      cmp(statusRequest[4], 1'b0);
    end
  endtask
  task automatic zeroRun;
    line.sendBits(5, 7, 1'b0);
    settle;
    rdChk(5, REGS[5], 8'h00);
    line.sendBits(5, 1, 1'b0);
    settle;
    rdChk(5, REGS[5], 8'h10);
    line.sendBits(5, 8, 1'b0);
    settle;
    rdChk(5, REGS[5], 8'h18);
    line.sendBits(5, 175, 1'b0);
    settle;
    rdChk(5, REGS[4], 8'h00);
    cmp(statusRequest[5], 1'b0);
    line.sendBits(5, 1, 1'b0);
    settle;
    rdChk(5, REGS[4], 8'h02);
    line.sendBits(5, 1, 1'b1);
    settle;
    rdChk(5, REGS[4], 8'h22);
  endtask
  task automatic events;
    for (int b = 0; b < 7; b++) line.pulseEvent(6, b);
    settle;
    rdChk(6, REGS[5], 8'h27);
    cmp(statusRequest[6], 1'b0);
    apb(1'b1, 6, REGS[5], 8'hFF);
    apb(1'b1, 6, REGS[3], 8'h01);
    for (int b = 0; b < 7; b++) begin
      line.pulseEvent(6, b);
      settle;
      rdChk(6, REGS[5], 8'h01 << b);
      cmp(statusRequest[6], b < 4);
      apb(1'b1, 6, REGS[5], 8'h01 << b);
    end
  endtask

  // hang guard well above the fewer than one thousand cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    resetValues;
    ctlRouting;
    suppress;
    alarms;
    zeroRun;
    events;
    final_report;
  end
endmodule
`default_nettype wire
